// ===== bench/mie_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// program memory partner
// ****************************************
module mie_fetch_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fetch port
  input wire logic [12:0] fetch_addr,
  input wire logic fetch_req,
  output logic fetch_valid,
  output logic [13:0] fetch_data
);
  logic [13:0] mem [8192];
  logic [13:0] last_word;
  logic [12:0] alog [64];
  int tlog [64];
  int lat;
  int wait_cnt;
  int cyc;
  int n_fetch;
  initial begin
    foreach (mem[i]) mem[i] = 14'h0000;
    lat = 0;
    wait_cnt = 0;
    last_word = 14'h0000;
  end
  // answer after lat cycles; idle data is the inverse of the last word
  assign fetch_valid = fetch_req && (wait_cnt >= lat);
  assign fetch_data = fetch_valid ? mem[fetch_addr] : ~last_word;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 0;
      cyc <= 0;
      n_fetch <= 0;
    end else begin
      cyc <= cyc + 1;
      wait_cnt <= (fetch_req && !fetch_valid) ? wait_cnt + 1 : 0;
      if (fetch_valid) begin
        last_word <= fetch_data;
        alog[n_fetch[5:0]] <= fetch_addr;
        tlog[n_fetch[5:0]] <= cyc;
        n_fetch <= n_fetch + 1;
      end
    end
  end
endmodule : mie_fetch_model
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mie_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [12:0] fetch_addr;
  logic fetch_req;
  logic fetch_valid;
  logic [13:0] fetch_data;
  logic [31:0] rd;
  logic er;
  logic [13:0] q[$];
  int n_errors = 0;
  int check_count = 0;
  always #2.5 pclk = ~pclk;
  mie_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_addr(fetch_addr), .fetch_req(fetch_req), .fetch_valid(fetch_valid), .fetch_data(fetch_data));
  mie_fetch_model far_u (.pclk(pclk), .presetn(presetn), .fetch_addr(fetch_addr),
    .fetch_req(fetch_req), .fetch_valid(fetch_valid), .fetch_data(fetch_data));
  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look mid-cycle, then complete at the edge that samples pready
    do begin
      @(negedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) n_errors++;
  endtask : apb
  // reset, load program, run until nf words fetched, read status
  task run(input logic [4:0] pcl, input int nf, input int lat);
    int k;
    k = 0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    far_u.lat = lat;
    for (int i = 0; i < 64; i++) far_u.mem[i] = (i < q.size()) ? q[i] : 14'h0000;
    apb(1'b1, MIE_ADDR_HILATCH, {27'h000_0000, pcl});
    apb(1'b1, MIE_ADDR_CTRL, 32'h0000_0001);
    while (far_u.n_fetch < nf && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 2000) n_errors++;
    apb(1'b1, MIE_ADDR_CTRL, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    apb(1'b0, MIE_ADDR_STAT, 32'h0000_0000);
  endtask : run
  task give_verdict;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // ****************************************
  // scenarios
  // ****************************************
  task t_regs;
    apb(1'b0, MIE_ADDR_HILATCH, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, MIE_ADDR_HILATCH, 32'h0000_0018);
    apb(1'b0, MIE_ADDR_HILATCH, 32'h0000_0000);
    chk(rd, 32'h0000_0018);
    apb(1'b1, MIE_ADDR_PC, 32'h0000_0055);
    apb(1'b0, MIE_ADDR_PC, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    $display("done t_regs");
  endtask : t_regs
  task t_sub;
    logic [7:0] tw[4] = '{8'h03, 8'h02, 8'h01, 8'h18};
    logic [7:0] tk[4] = '{8'h02, 8'h02, 8'h02, 8'h21};
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      q = '{14'h01A0, 14'h06A0, 14'h0620, {6'h3A, tw[i]}, {6'h3C, tk[i]}};
      r = tk[i] - tw[i];
      run(5'h00, 7, 0);
      chk(rd & 32'h0000_07FF, {21'h0, r == 8'h00, tk[i][3:0] >= tw[i][3:0], tk[i] >= tw[i], r});
    end
    $display("done t_sub");
  endtask : t_sub
  task t_subr_swap;
    q = '{14'h01A0, 14'h06A0, 14'h0620, 14'h01A1, 14'h3A52, 14'h06A1, 14'h3A45, 14'h02A1, 14'h0E21};
    run(5'h00, 11, 0);
    chk(rd & 32'h0000_07FF, 32'h0000_01B3);
    $display("done t_subr_swap");
  endtask : t_subr_swap
  task t_clr_dir;
    q = '{14'h01A0, 14'h06A0, 14'h0620, 14'h3A44, 14'h06A0, 14'h0066, 14'h01A0, 14'h0620, 14'h3A0F,
      14'h0606, 14'h01A3};
    run(5'h00, 13, 2);
    chk(rd & 32'h0000_04FF, 32'h0000_040F);
    $display("done t_clr_dir");
  endtask : t_clr_dir
  task t_skip_call;
    q = '{14'h01A4, 14'h06A4, 14'h0624, 14'h3A02, 14'h06A4, 14'h1CA4, 14'h3AFF, 14'h1C24, 14'h3A01, 14'h2123};
    run(5'h18, 12, 0);
    chk(rd & 32'h0000_04FF, 32'h0000_0003);
    chk({19'h0, far_u.alog[6]}, 32'h0000_0007);
    chk(32'(far_u.tlog[6] - far_u.tlog[5]), 32'h0000_0004);
    chk(32'(far_u.tlog[7] - far_u.tlog[6]), 32'h0000_0002);
    chk(32'(far_u.tlog[9] - far_u.tlog[8]), 32'h0000_0004);
    chk({19'h0, far_u.alog[9]}, 32'h0000_1923);
    apb(1'b0, MIE_ADDR_STKTOP, 32'h0000_0000);
    chk(rd, 32'h0000_000A);
    $display("done t_skip_call");
  endtask : t_skip_call
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_sub;
    t_subr_swap;
    t_clr_dir;
    t_skip_call;
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    give_verdict;
  end
endmodule : tb_top
`default_nettype wire

// ===== hw/mie_core.sv
`timescale 1ns/1ps
`default_nettype none
module mie_core
  import mie_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // program memory fetch
  output logic [12:0] fetch_addr,
  output logic fetch_req,
  input wire logic fetch_valid,
  input wire logic [13:0] fetch_data
);

  // ****************************************
  // decode
  // ****************************************
  function automatic mie_op_t mie_decode(input logic [13:0] i);
    mie_op_t o;
    o = MIE_OP_NOP;
    if (i[13:10] == MIE_ENC_SKIP) o = MIE_OP_SKIP;
    else if (i[13:11] == MIE_ENC_CALL) o = MIE_OP_CALL;
    else if (i[13:7] == MIE_ENC_CLR) o = MIE_OP_CLR;
    else if (i[13:9] == MIE_ENC_SUBL) o = MIE_OP_SUBL;
    else if (i[13:8] == MIE_ENC_SUBR) o = MIE_OP_SUBR;
    else if (i[13:8] == MIE_ENC_SWAP) o = MIE_OP_SWAP;
    else if (i[13:8] == MIE_ENC_XORL) o = MIE_OP_XORL;
    else if (i[13:8] == MIE_ENC_XORR) o = MIE_OP_XORR;
    else if (i[13:3] == MIE_ENC_DIR && i[2:0] >= MIE_DIR_LO && i[2:0] <= MIE_DIR_HI) o = MIE_OP_DIR;
    return o;
  endfunction : mie_decode

  function automatic logic mie_mapped(input logic [7:0] a);
    return a == MIE_ADDR_CTRL || a == MIE_ADDR_STAT || a == MIE_ADDR_HILATCH ||
           a == MIE_ADDR_PC || a == MIE_ADDR_STKTOP;
  endfunction : mie_mapped

  mie_state_t state_reg;
  mie_state_t state_next;
  mie_op_t op;
  logic [7:0] mem_rdata;
  logic [6:0] mem_raddr;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic mem_we;
  logic [7:0] sub_a;
  logic [8:0] sub_sum;
  logic [7:0] res;
  logic wr_dest;
  logic [12:0] stack_top;

  assign op = mie_decode(state_reg.instr);
  assign stack_top = state_reg.stack[state_reg.sp - 3'h1];

  // ****************************************
  // data register file
  // ****************************************
  mie_regfile #(.AW(7), .DW(8)) u_regfile (
    .pclk(pclk),
    .presetn(presetn),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    mem_raddr = fetch_data[6:0];
    mem_we = 1'b0;
    mem_waddr = state_reg.instr[6:0];
    mem_wdata = 8'h00;
    res = 8'h00;
    wr_dest = 1'b0;
    // subtrahend is always the accumulator
    sub_a = (op == MIE_OP_SUBL) ? state_reg.instr[7:0] : mem_rdata;
    sub_sum = {1'b0, sub_a} + {1'b0, ~state_reg.acc} + 9'h001;

    // apb: answer in the first access cycle
    if (psel && !penable) begin
      state_next.pready = 1'b1;
      state_next.pslverr = !mie_mapped(paddr);
      state_next.prdata = 32'h0000_0000;
      case (paddr)
        MIE_ADDR_CTRL: state_next.prdata[0] = state_reg.run;
        MIE_ADDR_STAT: state_next.prdata[10:0] = {state_reg.fl.z, state_reg.fl.nb, state_reg.fl.c, state_reg.acc};
        MIE_ADDR_HILATCH: state_next.prdata[4:0] = state_reg.hi_latch;
        MIE_ADDR_PC: state_next.prdata[12:0] = state_reg.pc;
        MIE_ADDR_STKTOP: state_next.prdata[12:0] = stack_top;
        default: state_next.prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && state_reg.pready && pwrite) begin
      case (paddr)
        MIE_ADDR_CTRL: state_next.run = pwdata[0];
        MIE_ADDR_HILATCH: state_next.hi_latch = pwdata[4:0];
        default: state_next.run = state_reg.run;
      endcase
    end

    case (state_reg.st)
      MIE_S_FETCH: begin
        if (state_reg.run && fetch_valid) begin
          state_next.instr = fetch_data;
          state_next.pc = state_reg.pc + MIE_PC_STEP;
          state_next.st = MIE_S_EXEC;
        end
      end
      MIE_S_EXEC: begin
        state_next.st = MIE_S_FETCH;
        case (op)
          MIE_OP_SKIP: begin
            // next word is passed over as a no-operation cycle
            if (mem_rdata[state_reg.instr[9:7]]) begin
              state_next.pc = state_reg.pc + MIE_PC_STEP;
              state_next.st = MIE_S_NOP_A;
            end
          end
          MIE_OP_CALL: begin
            state_next.stack[state_reg.sp] = state_reg.pc;
            state_next.sp = state_reg.sp + 3'h1;
            state_next.pc = {state_reg.hi_latch[4:3], state_reg.instr[10:0]};
            state_next.st = MIE_S_NOP_A;
          end
          MIE_OP_CLR: begin
            mem_we = 1'b1;
            mem_wdata = 8'h00;
            state_next.fl.z = 1'b1;
          end
          MIE_OP_SUBL: begin
            state_next.acc = sub_sum[7:0];
            state_next.fl.c = sub_sum[8];
            state_next.fl.nb = sub_a[3:0] >= state_reg.acc[3:0];
            state_next.fl.z = sub_sum[7:0] == 8'h00;
          end
          MIE_OP_SUBR: begin
            res = sub_sum[7:0];
            wr_dest = 1'b1;
            state_next.fl.c = sub_sum[8];
            state_next.fl.nb = sub_a[3:0] >= state_reg.acc[3:0];
            state_next.fl.z = sub_sum[7:0] == 8'h00;
          end
          MIE_OP_SWAP: begin
            res = {mem_rdata[3:0], mem_rdata[7:4]};
            wr_dest = 1'b1;
          end
          MIE_OP_DIR: begin
            mem_we = 1'b1;
            mem_waddr = {4'h0, state_reg.instr[2:0]};
            mem_wdata = state_reg.acc;
          end
          MIE_OP_XORL: begin
            state_next.acc = state_reg.acc ^ state_reg.instr[7:0];
            state_next.fl.z = (state_reg.acc ^ state_reg.instr[7:0]) == 8'h00;
          end
          MIE_OP_XORR: begin
            res = state_reg.acc ^ mem_rdata;
            wr_dest = 1'b1;
            state_next.fl.z = res == 8'h00;
          end
          default: state_next.st = MIE_S_FETCH;
        endcase
        if (wr_dest) begin
          if (state_reg.instr[7]) begin
            mem_we = 1'b1;
            mem_wdata = res;
          end else begin
            state_next.acc = res;
          end
        end
      end
      MIE_S_NOP_A: state_next.st = MIE_S_NOP_B;
      MIE_S_NOP_B: state_next.st = MIE_S_FETCH;
      default: state_next.st = MIE_S_FETCH;
    endcase
    state_next.fetch_req = state_next.run && state_next.st == MIE_S_FETCH;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.st <= MIE_S_FETCH;
      state_reg.pc <= MIE_PC_RESET;
      state_reg.hi_latch <= MIE_HILATCH_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign fetch_addr = state_reg.pc;
  assign fetch_req = state_reg.fetch_req;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic in_exec;
  assign in_exec = state_reg.st == MIE_S_EXEC;

  sequence seq_skip_taken;
    in_exec && op == MIE_OP_SKIP && mem_rdata[state_reg.instr[9:7]];
  endsequence
  sequence seq_two_cycle_tail;
    state_reg.st == MIE_S_NOP_A ##1 state_reg.st == MIE_S_NOP_B ##1 state_reg.st == MIE_S_FETCH;
  endsequence
  sequence seq_apb_setup;
    psel && !penable;
  endsequence

  chk_skip_next: assert property (seq_skip_taken |=>
      state_reg.pc == $past(state_reg.pc) + MIE_PC_STEP ##0 seq_two_cycle_tail)
    else $error("skip did not pass over next word");
  chk_call_push: assert property (in_exec && op == MIE_OP_CALL |=>
      stack_top == $past(state_reg.pc) ##0 seq_two_cycle_tail)
    else $error("call return address or length wrong");
  chk_call_target: assert property (in_exec && op == MIE_OP_CALL |=>
      state_reg.pc == {$past(state_reg.hi_latch[4:3]), $past(state_reg.instr[10:0])})
    else $error("call target wrong");
  chk_clr_zero: assert property (in_exec && op == MIE_OP_CLR |->
      mem_we && mem_wdata == 8'h00 ##1 state_reg.fl.z && state_reg.st == MIE_S_FETCH)
    else $error("clear did not zero register or set flag");
  chk_sub_borrow: assert property (in_exec && (op == MIE_OP_SUBL || op == MIE_OP_SUBR) |=>
      state_reg.fl.c == ($past(sub_a) >= $past(state_reg.acc)))
    else $error("borrow flag wrong");
  chk_subl_result: assert property (in_exec && op == MIE_OP_SUBL |=>
      state_reg.acc == 8'($past(state_reg.instr[7:0]) - $past(state_reg.acc)))
    else $error("literal subtraction result wrong");
  chk_dest_select: assert property (in_exec && op == MIE_OP_XORR && !state_reg.instr[7] |=>
      state_reg.acc == ($past(state_reg.acc) ^ $past(mem_rdata)))
    else $error("accumulator destination not written");
  chk_swap_flags: assert property (in_exec && op == MIE_OP_SWAP |=> $stable(state_reg.fl))
    else $error("nibble exchange changed flags");
  chk_xorl_zero: assert property (in_exec && op == MIE_OP_XORL |=>
      state_reg.fl.z == (state_reg.acc == 8'h00) && $stable(state_reg.fl.c) && $stable(state_reg.fl.nb))
    else $error("xor zero flag wrong");
  chk_nibble_borrow: assert property (in_exec && op == MIE_OP_SUBR |=>
      state_reg.fl.nb == ($past(mem_rdata[3:0]) >= $past(state_reg.acc[3:0])))
    else $error("nibble borrow flag wrong");
  chk_dir_write: assert property (in_exec && op == MIE_OP_DIR |->
      mem_we && mem_wdata == state_reg.acc && mem_waddr[2:0] >= MIE_DIR_LO)
    else $error("direction load write wrong");

  chk_dir_quiet: assert property (in_exec && op == MIE_OP_DIR |=>
      $stable(state_reg.fl) && $stable(state_reg.acc))
    else $error("direction load changed accumulator or flags");
  chk_skip_stay: assert property (in_exec && op == MIE_OP_SKIP && !mem_rdata[state_reg.instr[9:7]] |=>
      state_reg.st == MIE_S_FETCH && state_reg.pc == $past(state_reg.pc))
    else $error("skip taken although bit clear");
  chk_call_depth: assert property (in_exec && op == MIE_OP_CALL |=>
      state_reg.sp == 3'($past(state_reg.sp) + 3'h1))
    else $error("call did not advance the return stack");
  chk_clr_target: assert property (in_exec && op == MIE_OP_CLR |->
      mem_waddr == state_reg.instr[6:0] ##1 $stable(state_reg.acc))
    else $error("clear wrote the wrong register");
  chk_subr_result: assert property (in_exec && op == MIE_OP_SUBR && state_reg.instr[7] |->
      mem_we && mem_waddr == state_reg.instr[6:0] && mem_wdata == 8'(mem_rdata - state_reg.acc))
    else $error("register subtraction result wrong");
  chk_dest_file: assert property (in_exec && op == MIE_OP_XORR && state_reg.instr[7] |->
      mem_we && mem_wdata == (state_reg.acc ^ mem_rdata) ##1 $stable(state_reg.acc))
    else $error("register destination not written");
  chk_swap_value: assert property (in_exec && op == MIE_OP_SWAP && !state_reg.instr[7] |=>
      state_reg.acc[7:4] == $past(mem_rdata[3:0]) && state_reg.acc[3:0] == $past(mem_rdata[7:4]))
    else $error("nibble exchange result wrong");
  chk_xorl_value: assert property (in_exec && op == MIE_OP_XORL |=>
      state_reg.acc == ($past(state_reg.acc) ^ $past(state_reg.instr[7:0])))
    else $error("literal xor result wrong");
  chk_xorr_flags: assert property (in_exec && op == MIE_OP_XORR |=>
      $stable(state_reg.fl.c) && $stable(state_reg.fl.nb))
    else $error("register xor changed borrow flags");
  chk_subr_zero: assert property (in_exec && op == MIE_OP_SUBR |=>
      state_reg.fl.z == ($past(mem_rdata) == $past(state_reg.acc)))
    else $error("subtraction zero flag wrong");
  chk_subl_nibble: assert property (in_exec && op == MIE_OP_SUBL |=>
      state_reg.fl.nb == ($past(state_reg.instr[3:0]) >= $past(state_reg.acc[3:0])))
    else $error("literal nibble borrow flag wrong");
  chk_apb_answer: assert property (seq_apb_setup |=> pready)
    else $error("register bus answer missing");
  chk_apb_pulse: assert property (pready |=> !pready)
    else $error("register bus ready held too long");

endmodule : mie_core
`default_nettype wire

// ===== hw/mie_pkg.sv
// What this block does
// - skip_if_bit_set with chosen bit one discards next instruction; takes two cycles.
// - subroutine call pushes the following address onto the return stack; two cycles.
// - call loads 11-bit target into pc<10:0>, pc<12:11> from high latch bits 4:3.
// - clear_register writes zero to the register and sets null_result_flag; one cycle.
// - literal_minus_accumulator: literal minus accumulator into accumulator, sets three flags.
// - after subtraction borrow_inverted_flag is one for result zero or positive.
// - register_minus_accumulator: register minus accumulator, three flags, one cycle.
// - result_target_select zero writes accumulator, one writes the addressed register.
// - nibble_exchange swaps the register's nibbles into the destination; flags unchanged.
// - direction_load copies accumulator into direction register 5 to 7, also plain registers.
// - xor_literal: accumulator xor literal into accumulator, only null_result_flag changes.
// - xor_register: accumulator xor register to destination, only null_result_flag changes.
package mie_pkg;

  // ****************************************
  // apb register map
  // ****************************************
  localparam logic [7:0] MIE_ADDR_CTRL = 8'h00;
  localparam logic [7:0] MIE_ADDR_STAT = 8'h04;
  localparam logic [7:0] MIE_ADDR_HILATCH = 8'h08;
  localparam logic [7:0] MIE_ADDR_PC = 8'h0C;
  localparam logic [7:0] MIE_ADDR_STKTOP = 8'h10;
  localparam logic [4:0] MIE_HILATCH_RESET = 5'h00;
  localparam logic [12:0] MIE_PC_RESET = 13'h0000;
  localparam logic [12:0] MIE_PC_STEP = 13'h0001;
  localparam int unsigned MIE_STACK_DEPTH = 8;

  // ****************************************
  // instruction encodings
  // ****************************************
  localparam logic [3:0] MIE_ENC_SKIP = 4'h7;
  localparam logic [2:0] MIE_ENC_CALL = 3'h4;
  localparam logic [6:0] MIE_ENC_CLR = 7'h03;
  localparam logic [5:0] MIE_ENC_SUBR = 6'h02;
  localparam logic [5:0] MIE_ENC_SWAP = 6'h0E;
  localparam logic [5:0] MIE_ENC_XORR = 6'h06;
  localparam logic [4:0] MIE_ENC_SUBL = 5'h1E;
  localparam logic [5:0] MIE_ENC_XORL = 6'h3A;
  localparam logic [10:0] MIE_ENC_DIR = 11'h00C;
  localparam logic [2:0] MIE_DIR_LO = 3'h5;
  localparam logic [2:0] MIE_DIR_HI = 3'h7;

  typedef enum logic [2:0] {
    MIE_S_FETCH = 3'h0,
    MIE_S_EXEC = 3'h1,
    MIE_S_NOP_A = 3'h2,
    MIE_S_NOP_B = 3'h3
  } mie_st_t;

  typedef enum logic [3:0] {
    MIE_OP_NOP = 4'h0,
    MIE_OP_SKIP = 4'h1,
    MIE_OP_CALL = 4'h2,
    MIE_OP_CLR = 4'h3,
    MIE_OP_SUBL = 4'h4,
    MIE_OP_SUBR = 4'h5,
    MIE_OP_SWAP = 4'h6,
    MIE_OP_DIR = 4'h7,
    MIE_OP_XORL = 4'h8,
    MIE_OP_XORR = 4'h9
  } mie_op_t;

  typedef struct packed {
    logic c;
    logic nb;
    logic z;
  } mie_flags_t;

  typedef struct packed {
    mie_st_t st;
    logic run;
    logic fetch_req;
    logic [4:0] hi_latch;
    logic [12:0] pc;
    logic [13:0] instr;
    logic [7:0] acc;
    mie_flags_t fl;
    logic [2:0] sp;
    logic [MIE_STACK_DEPTH-1:0][12:0] stack;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mie_state_t;

endpackage : mie_pkg

// ===== hw/mie_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module mie_regfile #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read port, data one cycle later
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule : mie_regfile
`default_nettype wire
